/* design/fc_flash_host.sv */
// Host-side bus controller that drives a parallel flash through its pins and polls algorithm status.
`timescale 1ns/1ps
module fc_flash_host
  import fc_pkg::*;
#(
  parameter int unsigned RECOVERY_BUSY_CYC = RESET_RECOVERY_BUSY_CYC,
  parameter int unsigned UNPROTECT_PULSE_CYC = UNPROTECT_PULSE_WIDTH_CYC,
  parameter int unsigned RESUME_WAIT_CYC = RESUME_DELAY_CYC
) (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // User command port.
  input wire logic CMD_VALID_I,
  input wire logic [3:0] CMD_OP_I,
  input wire logic [17:0] CMD_ADDR_I,
  input wire logic [7:0] CMD_DATA_I,
  input wire logic RESUME_DELAY_ALWAYS_I,
  output logic CMD_READY_O,
  output logic DONE_O,
  output logic [7:0] RDATA_O,
  output logic [10:0] SUSPEND_COUNT_O,
  // Flash pins.
  output logic CE_N_O,
  output logic OE_N_O,
  output logic WE_N_O,
  output logic RESET_N_O,
  output logic SELECT_HV_O,
  output logic [17:0] ADDR_O,
  output logic [7:0] DQ_O,
  output logic DQ_OE_O,
  input wire logic [7:0] DQ_I,
  input wire logic READY_BUSY_N_I
);

  localparam fc_cnt_t RECOVERY_BUSY_W = fc_cnt_t'(RECOVERY_BUSY_CYC);
  localparam fc_cnt_t UNPROTECT_PULSE_W = fc_cnt_t'(UNPROTECT_PULSE_CYC);
  localparam fc_cnt_t RESUME_WAIT_W = fc_cnt_t'(RESUME_WAIT_CYC);

  fc_state_t st_r, st_nxt;
  fc_op_t op_r, op_nxt;
  fc_pins_t pins_r, pins_nxt;
  logic [7:0] exp_r, exp_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic ready_r, ready_nxt;
  logic done_r, done_nxt;
  logic first_r, first_nxt;
  logic last_r, last_nxt;
  logic prev_tog_r, prev_tog_nxt;
  logic was_busy_r, was_busy_nxt;
  logic [10:0] sr_cnt_r, sr_cnt_nxt;
  logic tmr_load;
  fc_cnt_t tmr_value;
  logic tmr_done;

  fc_timer i_fc_timer (.clk_i(CLK_I), .rst_n_i(RST_N_I), .load_i(tmr_load),
    .value_i(tmr_value), .done_o(tmr_done));

  always_comb begin
    st_nxt = st_r;
    op_nxt = op_r;
    pins_nxt = pins_r;
    exp_nxt = exp_r;
    rdata_nxt = rdata_r;
    ready_nxt = ready_r;
    done_nxt = 1'b0;
    first_nxt = first_r;
    last_nxt = last_r;
    prev_tog_nxt = prev_tog_r;
    was_busy_nxt = was_busy_r;
    sr_cnt_nxt = sr_cnt_r;
    tmr_load = 1'b0;
    tmr_value = WRITE_PULSE_CYC;
    case (st_r)
      ST_IDLE: begin
        if (CMD_VALID_I && ready_r) begin
          ready_nxt = 1'b0;
          op_nxt = fc_op_t'(CMD_OP_I);
          exp_nxt = CMD_DATA_I;
          first_nxt = 1'b1;
          last_nxt = 1'b0;
          pins_nxt.addr = CMD_ADDR_I;
          pins_nxt.dq = CMD_DATA_I;
          tmr_load = 1'b1;
          case (fc_op_t'(CMD_OP_I))
            OP_WRITE, OP_SUSPEND, OP_RESUME: begin
              // Program and erase setup cycles are plain writes; the flash verifies by itself.
              pins_nxt.dq = (fc_op_t'(CMD_OP_I) == OP_SUSPEND) ? SUSPEND_DATA :
                ((fc_op_t'(CMD_OP_I) == OP_RESUME) ? RESUME_DATA : CMD_DATA_I);
              pins_nxt.ce_n = 1'b0;
              pins_nxt.we_n = 1'b0;
              pins_nxt.dq_oe = 1'b1;
              tmr_value = WRITE_PULSE_CYC;
              st_nxt = ST_WR_LOW;
            end
            OP_READ, OP_POLL_POLARITY, OP_POLL_TOGGLE: begin
              pins_nxt.ce_n = 1'b0;
              pins_nxt.oe_n = 1'b0;
              tmr_value = READ_ACCESS_CYC;
              st_nxt = ST_RD_ACCESS;
            end
            OP_HW_RESET: begin
              was_busy_nxt = !READY_BUSY_N_I;
              pins_nxt.reset_n = 1'b0;
              tmr_value = RESET_PULSE_MIN_CYC;
              st_nxt = ST_RST_LOW;
            end
            OP_PROTECT, OP_UNPROTECT: begin
              pins_nxt.ce_n = 1'b0;
              pins_nxt.we_n = 1'b0;
              tmr_value = (fc_op_t'(CMD_OP_I) == OP_PROTECT) ? PROTECT_PULSE_WIDTH_CYC : UNPROTECT_PULSE_W;
              st_nxt = ST_PULSE;
            end
            OP_SELECT_ENTER: begin
              pins_nxt.select_hv = 1'b1;
              tmr_value = UNPROTECT_RESET_SETUP_CYC;
              st_nxt = ST_SEL_WAIT;
            end
            OP_SELECT_EXIT: begin
              pins_nxt.select_hv = 1'b0;
              tmr_value = SELECT_LEVEL_FALL_CYC;
              st_nxt = ST_SEL_WAIT;
            end
            default: begin
              // Unknown opcodes complete at once without a strobe; the address and data pins still take the command values.
              tmr_load = 1'b0;
              ready_nxt = 1'b1;
              done_nxt = 1'b1;
            end
          endcase
        end
      end
      ST_WR_LOW: begin
        if (tmr_done) begin
          pins_nxt.we_n = 1'b1;
          pins_nxt.ce_n = 1'b1;
          tmr_load = 1'b1;
          tmr_value = WRITE_HIGH_CYC;
          st_nxt = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH: begin
        if (tmr_done) begin
          pins_nxt.dq_oe = 1'b0;
          tmr_load = 1'b1;
          if (op_r == OP_SUSPEND) begin
            // The flash is not safe to access until the toggle bit settles.
            op_nxt = OP_POLL_TOGGLE;
            pins_nxt.ce_n = 1'b0;
            pins_nxt.oe_n = 1'b0;
            tmr_value = READ_ACCESS_CYC;
            st_nxt = ST_RD_ACCESS;
          end else if ((op_r == OP_RESUME) &&
              (RESUME_DELAY_ALWAYS_I || (sr_cnt_r >= 11'(SUSPEND_RESUME_LIMIT)))) begin
            tmr_value = RESUME_WAIT_W;
            st_nxt = ST_RESUME_WAIT;
          end else begin
            tmr_load = 1'b0;
            ready_nxt = 1'b1;
            done_nxt = 1'b1;
            st_nxt = ST_IDLE;
          end
          if ((op_r == OP_RESUME) && (sr_cnt_r != 11'h7ff)) begin
            sr_cnt_nxt = sr_cnt_r + 11'h001;
          end
        end
      end
      ST_RD_ACCESS: begin
        if (tmr_done) begin
          rdata_nxt = DQ_I;
          pins_nxt.ce_n = 1'b1;
          pins_nxt.oe_n = 1'b1;
          tmr_load = 1'b1;
          tmr_value = WRITE_HIGH_CYC + POLL_HOLD_CYC;
          st_nxt = ST_RD_GAP;
        end
      end
      ST_RD_GAP: begin
        if (tmr_done) begin
          first_nxt = 1'b0;
          prev_tog_nxt = rdata_r[6];
          if ((op_r == OP_READ) || last_r ||
              ((op_r == OP_POLL_TOGGLE) && !first_r && (rdata_r[6] == prev_tog_r))) begin
            ready_nxt = 1'b1;
            done_nxt = 1'b1;
            st_nxt = ST_IDLE;
          end else begin
            // The other status bits may settle a little after the polarity bit, so a match earns one more read.
            if ((op_r == OP_POLL_POLARITY) && (rdata_r[7] == exp_r[7])) begin
              last_nxt = 1'b1;
            end
            pins_nxt.ce_n = 1'b0;
            pins_nxt.oe_n = 1'b0;
            tmr_load = 1'b1;
            tmr_value = READ_ACCESS_CYC;
            st_nxt = ST_RD_ACCESS;
          end
        end
      end
      ST_RST_LOW: begin
        if (tmr_done) begin
          pins_nxt.reset_n = 1'b1;
          tmr_load = 1'b1;
          tmr_value = RESET_HIGH_BEFORE_READ_CYC;
          st_nxt = ST_RST_HIGH;
        end
      end
      ST_RST_HIGH: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_value = was_busy_r ? RECOVERY_BUSY_W : RESET_RECOVERY_IDLE_CYC;
          sr_cnt_nxt = SR_COUNT_RESET;
          st_nxt = ST_RST_RECOVER;
        end
      end
      ST_PULSE: begin
        if (tmr_done) begin
          pins_nxt.we_n = 1'b1;
          tmr_load = 1'b1;
          tmr_value = WRITE_HIGH_CYC;
          st_nxt = ST_PULSE_END;
        end
      end
      ST_PULSE_END, ST_RST_RECOVER, ST_SEL_WAIT, ST_RESUME_WAIT: begin
        if (tmr_done) begin
          // Chip select is already high in the other waits, so raising it here is harmless.
          pins_nxt.ce_n = 1'b1;
          ready_nxt = 1'b1;
          done_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        pins_nxt = PINS_RESET;
        ready_nxt = 1'b1;
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_r <= ST_IDLE;
      op_r <= OP_READ;
      pins_r <= PINS_RESET;
      exp_r <= DATA_RESET;
      rdata_r <= DATA_RESET;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      first_r <= 1'b0;
      last_r <= 1'b0;
      prev_tog_r <= 1'b0;
      was_busy_r <= 1'b0;
      sr_cnt_r <= SR_COUNT_RESET;
    end else begin
      st_r <= st_nxt;
      op_r <= op_nxt;
      pins_r <= pins_nxt;
      exp_r <= exp_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      first_r <= first_nxt;
      last_r <= last_nxt;
      prev_tog_r <= prev_tog_nxt;
      was_busy_r <= was_busy_nxt;
      sr_cnt_r <= sr_cnt_nxt;
    end
  end

  assign CMD_READY_O = ready_r;
  assign DONE_O = done_r;
  assign RDATA_O = rdata_r;
  assign SUSPEND_COUNT_O = sr_cnt_r;
  assign {CE_N_O, OE_N_O, WE_N_O, RESET_N_O, SELECT_HV_O, ADDR_O, DQ_O, DQ_OE_O} = pins_r;

endmodule

/* design/fc_pkg.sv */
// Shared types, opcodes and timing constants of the flash host controller.
package fc_pkg;

  typedef logic [21:0] fc_cnt_t;

  // Clock.
  localparam int unsigned CLK_PERIOD_NS = 4;

  // Flash pin timing, each in its own unit.
  localparam int unsigned WRITE_PULSE_NS = 35;
  localparam int unsigned WRITE_HIGH_NS = 30;
  localparam int unsigned READ_ACCESS_NS = 70;
  localparam int unsigned POLL_HOLD_NS = 10;
  localparam int unsigned RESET_PULSE_MIN_NS = 500;
  localparam int unsigned RESET_HIGH_BEFORE_READ_NS = 50;
  localparam int unsigned RESET_RECOVERY_IDLE_NS = 500;
  localparam int unsigned RESET_RECOVERY_BUSY_US = 20;
  localparam int unsigned UNPROTECT_RESET_SETUP_US = 4;
  localparam int unsigned SELECT_LEVEL_FALL_NS = 500;
  localparam int unsigned PROTECT_PULSE_WIDTH_US = 10;
  localparam int unsigned UNPROTECT_PULSE_WIDTH_MS = 12;
  localparam int unsigned RESUME_DELAY_MS = 10;
  localparam int unsigned SUSPEND_RESUME_LIMIT = 1024;

  // Every wait rounds up, so the host never waits less than the pin timing asks.
  localparam fc_cnt_t WRITE_PULSE_CYC = fc_cnt_t'((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam fc_cnt_t WRITE_HIGH_CYC = fc_cnt_t'((WRITE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam fc_cnt_t READ_ACCESS_CYC = fc_cnt_t'((READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam fc_cnt_t POLL_HOLD_CYC = fc_cnt_t'((POLL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam fc_cnt_t RESET_PULSE_MIN_CYC =
    fc_cnt_t'((RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam fc_cnt_t RESET_HIGH_BEFORE_READ_CYC =
    fc_cnt_t'((RESET_HIGH_BEFORE_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam fc_cnt_t RESET_RECOVERY_IDLE_CYC =
    fc_cnt_t'((RESET_RECOVERY_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned RESET_RECOVERY_BUSY_CYC =
    (RESET_RECOVERY_BUSY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam fc_cnt_t UNPROTECT_RESET_SETUP_CYC =
    fc_cnt_t'((UNPROTECT_RESET_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam fc_cnt_t SELECT_LEVEL_FALL_CYC =
    fc_cnt_t'((SELECT_LEVEL_FALL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam fc_cnt_t PROTECT_PULSE_WIDTH_CYC =
    fc_cnt_t'((PROTECT_PULSE_WIDTH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int unsigned UNPROTECT_PULSE_WIDTH_CYC =
    (UNPROTECT_PULSE_WIDTH_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESUME_DELAY_CYC = (RESUME_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Command data values written to the flash.
  localparam logic [7:0] SUSPEND_DATA = 8'hb0;
  localparam logic [7:0] RESUME_DATA = 8'h30;

  // Reset values.
  localparam logic [17:0] ADDR_RESET = 18'h00000;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [10:0] SR_COUNT_RESET = 11'h000;

  typedef enum logic [3:0] {
    OP_WRITE = 4'h0,
    OP_READ = 4'h1,
    OP_POLL_POLARITY = 4'h2,
    OP_POLL_TOGGLE = 4'h3,
    OP_SUSPEND = 4'h4,
    OP_RESUME = 4'h5,
    OP_HW_RESET = 4'h6,
    OP_PROTECT = 4'h7,
    OP_UNPROTECT = 4'h8,
    OP_SELECT_ENTER = 4'h9,
    OP_SELECT_EXIT = 4'ha
  } fc_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_WR_LOW = 4'h1,
    ST_WR_HIGH = 4'h2,
    ST_RD_ACCESS = 4'h3,
    ST_RD_GAP = 4'h4,
    ST_RST_LOW = 4'h5,
    ST_RST_HIGH = 4'h6,
    ST_RST_RECOVER = 4'h7,
    ST_PULSE = 4'h8,
    ST_PULSE_END = 4'h9,
    ST_SEL_WAIT = 4'ha,
    ST_RESUME_WAIT = 4'hb
  } fc_state_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_n;
    logic select_hv;
    logic [17:0] addr;
    logic [7:0] dq;
    logic dq_oe;
  } fc_pins_t;

  localparam fc_pins_t PINS_RESET = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, reset_n: 1'b1, select_hv: 1'b0,
                                      addr: ADDR_RESET, dq: DATA_RESET, dq_oe: 1'b0};

endpackage

/* design/fc_timer.sv */
// Load-and-count-down timer that pulses when the loaded number of cycles has passed.
`timescale 1ns/1ps
module fc_timer
  import fc_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control.
  input wire logic load_i,
  input wire fc_cnt_t value_i,
  // Status.
  output logic done_o
);

  fc_cnt_t cnt_r;
  fc_cnt_t cnt_nxt;
  logic done_r;
  logic done_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (load_i) begin
      cnt_nxt = value_i;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - fc_cnt_t'(1);
      done_nxt = (cnt_r == fc_cnt_t'(1));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r;

endmodule

/* verification/fc_flash_host_assertions.sv */
// Concurrent checks on the pins of the flash host controller.
`timescale 1ns/1ps
module fc_host_chk
  import fc_pkg::*;
#(
  parameter int unsigned RECOVERY_BUSY_CYC = RESET_RECOVERY_BUSY_CYC,
  parameter int unsigned UNPROTECT_PULSE_CYC = UNPROTECT_PULSE_WIDTH_CYC,
  parameter int unsigned RESUME_WAIT_CYC = RESUME_DELAY_CYC
) (
  // Clock and reset.
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Command side.
  input wire logic CMD_VALID_I,
  input wire logic [3:0] CMD_OP_I,
  input wire logic [17:0] CMD_ADDR_I,
  input wire logic [7:0] CMD_DATA_I,
  input wire logic RESUME_DELAY_ALWAYS_I,
  input wire logic CMD_READY_O,
  input wire logic DONE_O,
  input wire logic [7:0] RDATA_O,
  // Flash pins.
  input wire logic CE_N_O,
  input wire logic OE_N_O,
  input wire logic WE_N_O,
  input wire logic RESET_N_O,
  input wire logic SELECT_HV_O,
  input wire logic [17:0] ADDR_O,
  input wire logic [7:0] DQ_O,
  input wire logic DQ_OE_O,
  input wire logic READY_BUSY_N_I
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic take;
  logic [3:0] op_r;
  logic [17:0] addr_r;
  logic [7:0] dat_r;
  logic bsy_r;
  logic dly_r;
  int unsigned lo_cnt, hi_cnt, we_cnt, hv_cnt, tk_cnt;
  assign take = CMD_VALID_I && CMD_READY_O;
  // Level lengths are counted so that minimum widths are judged at the closing edge, or at a read or DONE_O while the level holds.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      op_r <= 4'h0;
      addr_r <= 18'h00000;
      dat_r <= 8'h00;
      bsy_r <= 1'b0;
      dly_r <= 1'b0;
      lo_cnt <= 0;
      hi_cnt <= 1000;
      we_cnt <= 0;
      hv_cnt <= 0;
      tk_cnt <= 0;
    end else begin
      if (take) begin
        op_r <= CMD_OP_I;
        addr_r <= CMD_ADDR_I;
        dat_r <= CMD_DATA_I;
        bsy_r <= !READY_BUSY_N_I;
        dly_r <= RESUME_DELAY_ALWAYS_I;
      end
      lo_cnt <= RESET_N_O ? 0 : lo_cnt + 1;
      hi_cnt <= !RESET_N_O ? 0 : hi_cnt + 1;
      we_cnt <= WE_N_O ? 0 : we_cnt + 1;
      hv_cnt <= !SELECT_HV_O ? 0 : hv_cnt + 1;
      tk_cnt <= take ? 0 : tk_cnt + 1;
    end
  end
  sequence s_take(logic [3:0] op);
    take && CMD_OP_I == op;
  endsequence
  sequence s_write(logic [7:0] d);
    !CE_N_O && !WE_N_O && DQ_OE_O && DQ_O == d;
  endsequence
  property p_suspend_data;
    s_take(OP_SUSPEND) |=> s_write(SUSPEND_DATA);
  endproperty
  a_suspend_data: assert property (p_suspend_data) else $error("suspend data wrong");
  property p_resume_data;
    s_take(OP_RESUME) |=> s_write(RESUME_DATA);
  endproperty
  a_resume_data: assert property (p_resume_data) else $error("resume data wrong");
  property p_we_width;
    $fell(WE_N_O) |=> !WE_N_O [*8];
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe too short");
  property p_read_gap;
    $rose(OE_N_O) |-> CE_N_O [*8];
  endproperty
  a_read_gap: assert property (p_read_gap) else $error("chip select not raised between reads");
  property p_pol_addr;
    $fell(OE_N_O) && op_r == OP_POLL_POLARITY |-> ADDR_O == addr_r;
  endproperty
  a_pol_addr: assert property (p_pol_addr) else $error("status read at wrong address");
  property p_pol_done;
    DONE_O && op_r == OP_POLL_POLARITY |-> RDATA_O[7] == dat_r[7];
  endproperty
  a_pol_done: assert property (p_pol_done) else $error("polarity poll ended early");
  property p_rst_pulse;
    $rose(RESET_N_O) |-> lo_cnt >= RESET_PULSE_MIN_CYC;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too short");
  property p_rst_high;
    $fell(OE_N_O) |-> hi_cnt >= RESET_HIGH_BEFORE_READ_CYC;
  endproperty
  a_rst_high: assert property (p_rst_high) else $error("read too soon after reset");
  property p_rst_recover;
    DONE_O && op_r == OP_HW_RESET |-> hi_cnt >= (bsy_r ? RECOVERY_BUSY_CYC : RESET_RECOVERY_IDLE_CYC);
  endproperty
  a_rst_recover: assert property (p_rst_recover) else $error("reset recovery too short");
  property p_protect;
    $rose(WE_N_O) && op_r == OP_PROTECT |-> we_cnt >= PROTECT_PULSE_WIDTH_CYC;
  endproperty
  a_protect: assert property (p_protect) else $error("protect pulse too short");
  property p_unprotect;
    $rose(WE_N_O) && op_r == OP_UNPROTECT |-> we_cnt >= UNPROTECT_PULSE_CYC;
  endproperty
  a_unprotect: assert property (p_unprotect) else $error("unprotect pulse too short");
  property p_select;
    DONE_O && op_r == OP_SELECT_ENTER |-> SELECT_HV_O && hv_cnt >= UNPROTECT_RESET_SETUP_CYC;
  endproperty
  a_select: assert property (p_select) else $error("select setup too short");
  property p_resume_wait;
    DONE_O && op_r == OP_RESUME && dly_r |-> tk_cnt >= RESUME_WAIT_CYC;
  endproperty
  a_resume_wait: assert property (p_resume_wait) else $error("resume delay skipped");
endmodule
bind fc_flash_host fc_host_chk #(.RECOVERY_BUSY_CYC(RECOVERY_BUSY_CYC), .UNPROTECT_PULSE_CYC(UNPROTECT_PULSE_CYC),
  .RESUME_WAIT_CYC(RESUME_WAIT_CYC)) i_fc_host_chk (.*);

/* verification/fc_flash_model.sv */
// Behavioural flash device with program, erase, suspend and status reads.
`timescale 1ns/1ps
module fc_flash_model #(
  parameter int PROG_CYC = 200,
  parameter int ERASE_CYC = 3000
) (
  // Internal algorithm timer clock.
  input wire logic clk_i,
  // Flash pins.
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic reset_n_i,
  input wire logic [17:0] addr_i,
  input wire logic [7:0] dq_i,
  output logic [7:0] dq_o,
  output logic ready_busy_n_o
);
  logic [7:0] mem [0:262143];
  logic [7:0] wd = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic [7:0] q;
  logic [17:0] wa = 18'h00000;
  logic erase = 1'b0;
  logic susp = 1'b0;
  logic tgl = 1'b0;
  logic we_q = 1'b1;
  logic rd_q = 1'b0;
  int left = 0;
  int pend = 0;
  initial foreach (mem[i]) mem[i] = 8'hff;
  assign q = (left != 0 && !susp) ? {erase ? 1'b0 : ~wd[7], tgl, 6'h00} : mem[addr_i];
  // A released bus shows the inverse of its last value rather than a settled guess.
  assign dq_o = (!ce_n_i && !oe_n_i) ? q : ~last_q;
  assign ready_busy_n_o = left == 0 || susp;
  // Pins are looked at on the falling clock edge, away from the host's launch edge.
  always @(negedge clk_i) begin
    if (!ce_n_i && !we_n_i) begin
      wa = addr_i;
      wd = dq_i;
    end
    if (!reset_n_i) begin
      left = 0;
      susp = 0;
      pend = 0;
    end else if (we_n_i && !we_q) begin
      if (left != 0 && !susp && wd == 8'hb0) pend = 50;
      else if (susp && wd == 8'h30) susp = 0;
      else if (left == 0 && wd == 8'h10) begin
        foreach (mem[i]) mem[i] = 8'hff;
        erase = 1;
        left = ERASE_CYC;
      end else if (left == 0 && wd == 8'h30) begin
        for (int i = 0; i < 4096; i++) mem[{wa[17:12], i[11:0]}] = 8'hff;
        erase = 1;
        left = ERASE_CYC;
      end else if (left == 0) begin
        mem[wa] = mem[wa] & wd;
        erase = 0;
        left = PROG_CYC;
      end
    end
    if (pend == 1) susp = 1;
    if (pend != 0) pend = pend - 1;
    if (left != 0 && !susp) left = left - 1;
    if (!ce_n_i && !oe_n_i && !rd_q && left != 0 && !susp) tgl = ~tgl;
    if (!ce_n_i && !oe_n_i) last_q = q;
    rd_q = !ce_n_i && !oe_n_i;
    we_q = we_n_i;
  end
endmodule

/* verification/fc_flash_host_tb_top.sv */
// Self-checking testbench of the flash host controller against the flash model.
`timescale 1ns/1ps
module fc_flash_host_tb_top;
  import fc_pkg::*;
  localparam int RB = 200;
  localparam int UP = 60;
  localparam int RW = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid = 1'b0;
  logic [3:0] op = 4'h0;
  logic [17:0] addr = 18'h00000;
  logic [7:0] data = 8'h00;
  logic dly = 1'b0;
  logic ready, done, ce_n, oe_n, we_n, reset_n, sel_hv, dq_oe, rbn;
  logic [7:0] rdata, dq_h, dq_f, dq_bus;
  logic [10:0] count;
  logic [17:0] pa;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int nrd = 0;
  always #2 clk = ~clk;
  always @(negedge oe_n) nrd++;
  assign dq_bus = dq_oe ? dq_h : dq_f;
  fc_flash_host #(.RECOVERY_BUSY_CYC(RB), .UNPROTECT_PULSE_CYC(UP), .RESUME_WAIT_CYC(RW)) i_fc_flash_host (
    .CLK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(valid), .CMD_OP_I(op), .CMD_ADDR_I(addr), .CMD_DATA_I(data),
    .RESUME_DELAY_ALWAYS_I(dly), .CMD_READY_O(ready), .DONE_O(done), .RDATA_O(rdata), .SUSPEND_COUNT_O(count),
    .CE_N_O(ce_n), .OE_N_O(oe_n), .WE_N_O(we_n), .RESET_N_O(reset_n), .SELECT_HV_O(sel_hv), .ADDR_O(pa),
    .DQ_O(dq_h), .DQ_OE_O(dq_oe), .DQ_I(dq_bus), .READY_BUSY_N_I(rbn));
  fc_flash_model i_fc_flash_model (.clk_i(clk), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .reset_n_i(reset_n),
    .addr_i(pa), .dq_i(dq_bus), .dq_o(dq_f), .ready_busy_n_o(rbn));
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmd(input logic [3:0] o, input logic [17:0] a, input logic [7:0] d);
    chk(ready, 1'b1);
    valid = 1'b1;
    op = o;
    addr = a;
    data = d;
    @(posedge clk);
    #1;
    valid = 1'b0;
    cyc = 0;
    while (done !== 1'b1) begin
      @(posedge clk);
      #1;
      cyc++;
      if (cyc > 20000) begin
        chk(1'b1, 1'b0);
        final_report();
      end
    end
  endtask
  task automatic t_erase();
    cmd(OP_WRITE, 18'h00040, 8'h00);
    cmd(OP_POLL_POLARITY, 18'h00040, 8'h00);
    cmd(OP_WRITE, 18'h00000, 8'h10);
    chk(rbn, 1'b0);
    cmd(OP_POLL_POLARITY, 18'h00040, 8'hff);
    chk(rdata, 8'hff);
    chk(rbn, 1'b1);
  endtask
  task automatic t_program();
    int n0;
    n0 = nrd;
    cmd(OP_WRITE, 18'h00123, 8'h5a);
    cmd(OP_POLL_POLARITY, 18'h00123, 8'h5a);
    chk(rdata, 8'h5a);
    chk(nrd - n0 > 2, 1'b1);
    cmd(OP_WRITE, 18'h21005, 8'h3c);
    cmd(OP_POLL_POLARITY, 18'h21005, 8'h3c);
    chk(rdata, 8'h3c);
  endtask
  task automatic t_suspend();
    cmd(OP_WRITE, 18'h21000, 8'h30);
    cmd(OP_SUSPEND, 18'h00000, 8'h00);
    chk(rbn, 1'b1);
    cmd(OP_READ, 18'h00123, 8'h00);
    chk(rdata, 8'h5a);
    cmd(OP_RESUME, 18'h00000, 8'h00);
    chk(count, 11'h001);
    chk(rbn, 1'b0);
    dly = 1'b1;
    cmd(OP_SUSPEND, 18'h00000, 8'h00);
    cmd(OP_RESUME, 18'h00000, 8'h00);
    chk(cyc > RW + 18, 1'b1);
    dly = 1'b0;
    cmd(OP_POLL_TOGGLE, 18'h3ffff, 8'h00);
    chk(rbn, 1'b1);
    cmd(OP_READ, 18'h21005, 8'h00);
    chk(rdata, 8'hff);
    cmd(OP_READ, 18'h00123, 8'h00);
    chk(rdata, 8'h5a);
  endtask
  task automatic t_reset();
    int lo;
    lo = RESET_PULSE_MIN_CYC + RESET_HIGH_BEFORE_READ_CYC + RB;
    cmd(OP_WRITE, 18'h00200, 8'h11);
    cmd(OP_HW_RESET, 18'h00000, 8'h00);
    chk(cyc >= lo && cyc < lo + 20, 1'b1);
    chk(rbn, 1'b1);
    chk(count, 11'h000);
    lo = RESET_PULSE_MIN_CYC + RESET_HIGH_BEFORE_READ_CYC + RESET_RECOVERY_IDLE_CYC;
    cmd(OP_HW_RESET, 18'h00000, 8'h00);
    chk(cyc >= lo && cyc < lo + 20, 1'b1);
    cmd(OP_READ, 18'h00123, 8'h00);
    chk(rdata, 8'h5a);
  endtask
  task automatic t_pulses();
    logic [3:0] ops [5];
    int lo [5];
    ops = '{OP_PROTECT, OP_UNPROTECT, OP_SELECT_ENTER, OP_SELECT_EXIT, 4'hf};
    lo = '{PROTECT_PULSE_WIDTH_CYC, UP, UNPROTECT_RESET_SETUP_CYC, SELECT_LEVEL_FALL_CYC, 0};
    for (int i = 0; i < 5; i++) begin
      cmd(ops[i], 18'h3ff00, 8'hff);
      chk(cyc >= lo[i] && cyc < lo[i] + 20, 1'b1);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_erase();
    t_program();
    t_suspend();
    t_reset();
    t_pulses();
    final_report();
  end
endmodule
